// File: inc/fpc_pkg.sv
package fpc_pkg;

  ////////////////////////////////////////////////////////////////////////////////
  // Clocking: the symbol rate is carried as bit slots per MII clock
  localparam int MCLK_MHZ = 25;
  localparam int SYM_MHZ = 125;
  localparam int BITS_PER_CLK = SYM_MHZ / MCLK_MHZ;

  // Code group and nibble widths
  localparam int CG_W = 5;
  localparam int NIB_W = 4;

  // Scrambler generator x^11 + x^9 + 1
  localparam int LFSR_W = 11;
  localparam int LFSR_TAP_HI = 10;
  localparam int LFSR_TAP_LO = 8;
  localparam logic [10:0] LFSR_SEED = 11'h7ff;

  // Idle groups seen before the descrambler counts as locked
  localparam int LOCK_GROUPS = 4;

  ////////////////////////////////////////////////////////////////////////////////
  // Special code groups
  localparam logic [4:0] CG_J = 5'h18;
  localparam logic [4:0] CG_K = 5'h11;
  localparam logic [4:0] CG_T = 5'h0d;
  localparam logic [4:0] CG_R = 5'h07;
  localparam logic [4:0] CG_IDLE = 5'h1f;
  localparam logic [4:0] CG_ERR = 5'h04;
  localparam logic [3:0] NIB_PREAMBLE = 4'h5;

  typedef logic [4:0] fpc_cg_t;

  // Data nibble to code group, indexed by nibble value
  localparam fpc_cg_t ENC_TABLE [16] = '{
    5'h1e, 5'h09, 5'h14, 5'h15, 5'h0a, 5'h0b, 5'h0e, 5'h0f,
    5'h12, 5'h13, 5'h16, 5'h17, 5'h1a, 5'h1b, 5'h1c, 5'h1d
  };

  ////////////////////////////////////////////////////////////////////////////////
  // Carriers
  typedef struct packed {
    logic en;
    logic er;
    logic [3:0] d;
  } fpc_mii_tx_s;

  typedef struct packed {
    logic dv;
    logic er;
    logic [3:0] d;
  } fpc_mii_rx_s;

  // Bit 4 is the earliest bit slot of the clock period
  typedef struct packed {
    logic [4:0] pos;
    logic [4:0] neg;
  } fpc_line_s;

  typedef struct packed {
    logic ok;
    logic [3:0] nib;
  } fpc_dec_s;

  typedef enum logic [1:0] {TX_IDLE, TX_K, TX_DATA, TX_R} fpc_tx_state_e;
  typedef enum logic [1:0] {RX_HUNT, RX_PRE1, RX_PRE2, RX_DATA} fpc_rx_state_e;

  // Inverse table lookup; control and invalid groups come back not ok
  function automatic fpc_dec_s fpc_decode(input fpc_cg_t cg);
    fpc_dec_s r;
    r = '0;
    for (int i = 0; i < 16; i++) begin
      if (ENC_TABLE[i] == cg) begin
        r.ok = 1'b1;
        r.nib = 4'(i);
      end
    end
    return r;
  endfunction

endpackage

// File: rtl/fpc_lfsr.sv
module fpc_lfsr
  import fpc_pkg::*;
#(
  parameter int STEPS = BITS_PER_CLK
) (
  input wire logic mclk_i,               // 25 MHz clock
  input wire logic resetn_i,             // Async reset, active low
  input wire logic learn_i,              // Load key from learn bits
  input wire logic [STEPS-1:0] learn_bits_i, // Key bits seen on line
  output logic [STEPS-1:0] key_o         // Key stream, msb first
);

  logic [LFSR_W-1:0] state_q;
  logic [LFSR_W-1:0] state_d;

  generate
    if (STEPS < 1 || LFSR_TAP_HI >= LFSR_W) begin : g_bad
      $error("fpc_lfsr: unsupported step count or tap");
    end
  endgenerate

  // Advance one generator step per bit slot
  always_comb begin
    logic fb;
    fb = 1'b0;
    state_d = state_q;
    key_o = '0;
    for (int j = STEPS - 1; j >= 0; j--) begin
      fb = state_d[LFSR_TAP_HI] ^ state_d[LFSR_TAP_LO];
      key_o[j] = fb;
      // Learning replaces the prediction with the observed key bit
      state_d = {state_d[LFSR_W-2:0], learn_i ? learn_bits_i[j] : fb};
    end
  end

  // Generator state
  always_ff @(posedge mclk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      state_q <= LFSR_SEED;
    end else begin
      state_q <= state_d;
    end
  end

  // A live generator never falls into the all-zero lockup
  lfsr_live_a: assert property (@(posedge mclk_i) disable iff (!resetn_i)
    !learn_i && state_q != '0 |=> state_q != '0)
    else $error("scrambler generator fell into all-zero state");

endmodule

// File: rtl/fpc_pcs_coding.sv
// Operation
// - Transmit takes one MII nibble per 25 MHz clock, sends coded 125 Mb/s.
// - Symbol timing is 125 MHz, carried as five bit slots per clock.
// - Each data nibble maps to its fixed 5-bit code group.
// - First two preamble nibbles are replaced by J then K.
// - Remaining preamble and data nibbles go out as data code groups.
// - On transmit enable falling, T then R are sent.
// - Idle groups fill the line until the next packet starts.
// - A bypass skips the 4B5B conversion for pre-coded symbols.
// - Scrambler XORs its key stream onto the 5-bit code data.
// - Scrambled groups are serialised into a bit stream.
// - The serial stream is NRZI encoded before MLT-3.
// - MLT-3 splits into two drive streams with alternating one events.
// - Receive turns the 125 Mb/s line data into MII nibbles.
// - The three-level input is decoded into an NRZI stream.
// - Line data is retimed and the receiver reports lock.
// - NRZI is turned back into NRZ before deserialising.
// - NRZ bits are gathered into parallel words for the descrambler.
// - The descrambler strips the key stream from parallel words.
// - Alignment finds J/K and cuts groups on that fixed boundary.
// - Aligned groups decode to nibbles by the inverse table.
// - Invalid groups and the error symbol decode to no data nibble.
// - J/K becomes two preamble nibbles; T/R is stripped.
// - Receive data valid covers the frame and excludes the end pair.
module fpc_pcs_coding
  import fpc_pkg::*;
#(
  parameter int LOCK_CNT = LOCK_GROUPS
) (
  input wire logic mclk_i,               // 25 MHz clock
  input wire logic resetn_i,             // Async reset, active low
  input wire fpc_mii_tx_s tx_mii_i,      // MII transmit group
  input wire logic tx_bypass_i,          // Send {er,d} as raw group
  output fpc_line_s tx_line_o,           // MLT-3 drive phases
  input wire fpc_line_s rx_line_i,       // Equalised three-level input
  output fpc_mii_rx_s rx_mii_o,          // MII receive group
  output logic rx_lock_o                 // Descrambler locked
);

  generate
    if (BITS_PER_CLK != CG_W || LOCK_CNT < 1 || LOCK_CNT > 15) begin : g_bad
      $error("fpc_pcs_coding: unsupported rate ratio or lock count");
    end
  endgenerate

  ////////////////////////////////////////////////////////////////////////////////
  // Transmit encoder

  fpc_tx_state_e tx_st_q;
  fpc_cg_t cg_q;

  // Code group selection, one group per MII clock
  always_ff @(posedge mclk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      tx_st_q <= TX_IDLE;
      cg_q <= CG_IDLE;
    end else if (tx_bypass_i) begin
      cg_q <= {tx_mii_i.er, tx_mii_i.d};
      tx_st_q <= TX_IDLE;
    end else begin
      case (tx_st_q)
        TX_IDLE: begin
          if (tx_mii_i.en) begin
            cg_q <= CG_J;
            tx_st_q <= TX_K;
          end else begin
            cg_q <= CG_IDLE;
          end
        end
        TX_K: begin
          cg_q <= CG_K;
          tx_st_q <= TX_DATA;
        end
        TX_DATA: begin
          // Nibble is trusted valid whenever enable is high
          if (tx_mii_i.en) begin
            cg_q <= tx_mii_i.er ? CG_ERR : ENC_TABLE[tx_mii_i.d];
          end else begin
            cg_q <= CG_T;
            tx_st_q <= TX_R;
          end
        end
        TX_R: begin
          // Enable rising here waits for idle so the end pair stays whole
          cg_q <= CG_R;
          tx_st_q <= TX_IDLE;
        end
        default: begin
          cg_q <= CG_IDLE;
          tx_st_q <= TX_IDLE;
        end
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Transmit scrambler, serialiser, NRZI and MLT-3

  logic [4:0] tx_key;
  logic [4:0] tx_scr;
  logic tx_nrzi_q;
  logic tx_nrzi_d;
  logic [1:0] tx_ph_q;
  logic [1:0] tx_ph_d;
  fpc_line_s tx_line_d;
  fpc_line_s tx_line_q;

  fpc_lfsr #(.STEPS(BITS_PER_CLK)) u_tx_lfsr (
    .mclk_i(mclk_i),
    .resetn_i(resetn_i),
    .learn_i(1'b0),
    .learn_bits_i('0),
    .key_o(tx_key)
  );

  assign tx_scr = cg_q ^ tx_key;

  // Walk the five bit slots in transmit order, bit 4 first
  always_comb begin
    logic prev;
    prev = tx_nrzi_q;
    tx_nrzi_d = tx_nrzi_q;
    tx_ph_d = tx_ph_q;
    tx_line_d = '0;
    for (int j = CG_W - 1; j >= 0; j--) begin
      tx_nrzi_d = tx_nrzi_d ^ tx_scr[j];
      // MLT-3 steps on each NRZI transition: 0, +, 0, -
      if (tx_nrzi_d != prev) begin
        tx_ph_d = tx_ph_d + 2'h1;
      end
      prev = tx_nrzi_d;
      tx_line_d.pos[j] = (tx_ph_d == 2'h1);
      tx_line_d.neg[j] = (tx_ph_d == 2'h3);
    end
  end

  // Line state and registered drive phases
  always_ff @(posedge mclk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      tx_nrzi_q <= 1'b0;
      tx_ph_q <= 2'h0;
      tx_line_q <= '0;
    end else begin
      tx_nrzi_q <= tx_nrzi_d;
      tx_ph_q <= tx_ph_d;
      tx_line_q <= tx_line_d;
    end
  end

  assign tx_line_o = tx_line_q;

  ////////////////////////////////////////////////////////////////////////////////
  // Receive front end: retime, MLT-3 to NRZI, NRZI to NRZ

  fpc_line_s rx_line_q;
  logic [1:0] rx_lvl_q;
  logic [1:0] rx_lvl_d;
  logic rx_nrzi_q;
  logic rx_nrzi_d;
  logic [4:0] rx_nrz;

  // Retime line slots onto the symbol timing
  always_ff @(posedge mclk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      rx_line_q <= '0;
    end else begin
      rx_line_q <= rx_line_i;
    end
  end

  // A level change marks an NRZI transition, a transition an NRZ one
  always_comb begin
    logic [1:0] lvl;
    logic prev;
    lvl = 2'h0;
    prev = rx_nrzi_q;
    rx_lvl_d = rx_lvl_q;
    rx_nrzi_d = rx_nrzi_q;
    rx_nrz = '0;
    for (int j = CG_W - 1; j >= 0; j--) begin
      lvl = {rx_line_q.pos[j], rx_line_q.neg[j]};
      rx_nrzi_d = rx_nrzi_d ^ (lvl != rx_lvl_d);
      rx_nrz[j] = rx_nrzi_d ^ prev;
      prev = rx_nrzi_d;
      rx_lvl_d = lvl;
    end
  end

  // Front end history
  always_ff @(posedge mclk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      rx_lvl_q <= 2'h0;
      rx_nrzi_q <= 1'b0;
    end else begin
      rx_lvl_q <= rx_lvl_d;
      rx_nrzi_q <= rx_nrzi_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Descrambler and lock

  fpc_rx_state_e rx_st_q;
  logic [4:0] rx_key;
  logic [4:0] rx_plain;
  logic [3:0] lock_cnt_q;
  logic locked;

  assign locked = (lock_cnt_q >= 4'(LOCK_CNT));

  // Learning assumes idle plaintext, so it stops once locked
  fpc_lfsr #(.STEPS(BITS_PER_CLK)) u_rx_lfsr (
    .mclk_i(mclk_i),
    .resetn_i(resetn_i),
    .learn_i(!locked),
    .learn_bits_i(~rx_nrz),
    .key_o(rx_key)
  );

  assign rx_plain = rx_nrz ^ rx_key;

  // Lock once enough idle groups descramble cleanly; kept until reset
  always_ff @(posedge mclk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      lock_cnt_q <= 4'h0;
    end else if (!locked) begin
      lock_cnt_q <= (rx_plain == CG_IDLE) ? lock_cnt_q + 4'h1 : 4'h0;
    end
  end

  assign rx_lock_o = locked;

  ////////////////////////////////////////////////////////////////////////////////
  // Code group alignment

  logic [9:0] hist_q;
  logic [14:0] win;
  logic hit;
  logic [2:0] hit_off;
  logic [2:0] off_q;
  fpc_cg_t grp;
  fpc_cg_t g1_q;
  fpc_cg_t g2_q;

  assign win = {hist_q, rx_plain};
  assign grp = win[off_q +: CG_W];

  // Search every bit offset for the J/K pair
  always_comb begin
    hit = 1'b0;
    hit_off = 3'h0;
    for (int o = 0; o < CG_W; o++) begin
      if (win[o +: 2 * CG_W] == {CG_J, CG_K}) begin
        hit = 1'b1;
        hit_off = 3'(o);
      end
    end
  end

  // Two-group delay makes room for the substituted preamble
  always_ff @(posedge mclk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      hist_q <= '0;
      g1_q <= CG_IDLE;
      g2_q <= CG_IDLE;
    end else begin
      hist_q <= win[9:0];
      g1_q <= grp;
      g2_q <= g1_q;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Receive decoder and MII output

  fpc_mii_rx_s rx_q;
  fpc_dec_s dec;

  assign dec = fpc_decode(g2_q);

  // Frame state, alignment offset and MII nibble
  always_ff @(posedge mclk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      rx_st_q <= RX_HUNT;
      off_q <= 3'h0;
      rx_q <= '0;
    end else begin
      case (rx_st_q)
        RX_HUNT: begin
          rx_q <= '0;
          if (locked && hit) begin
            off_q <= hit_off;
            rx_st_q <= RX_PRE1;
          end
        end
        RX_PRE1, RX_PRE2: begin
          rx_q <= '{dv: 1'b1, er: 1'b0, d: NIB_PREAMBLE};
          rx_st_q <= (rx_st_q == RX_PRE1) ? RX_PRE2 : RX_DATA;
        end
        RX_DATA: begin
          if ((g2_q == CG_T && g1_q == CG_R) || g2_q == CG_IDLE) begin
            rx_q <= '0;
            rx_st_q <= RX_HUNT;
          end else begin
            rx_q <= '{dv: 1'b1, er: !dec.ok, d: dec.nib};
          end
        end
        default: begin
          rx_q <= '0;
          rx_st_q <= RX_HUNT;
        end
      endcase
    end
  end

  assign rx_mii_o = rx_q;

  ////////////////////////////////////////////////////////////////////////////////
  // Checks

  default clocking @(posedge mclk_i); endclocking
  default disable iff (!resetn_i);

  sequence start_cause_s;
    tx_st_q == TX_IDLE && tx_mii_i.en && !tx_bypass_i ##1 !tx_bypass_i;
  endsequence

  sequence end_cause_s;
    tx_st_q == TX_DATA && !tx_mii_i.en && !tx_bypass_i ##1 !tx_bypass_i
      ##1 !tx_bypass_i && !tx_mii_i.en;
  endsequence

  sequence preamble_pair_s;
    rx_q.dv && rx_q.d == NIB_PREAMBLE ##1 rx_q.dv && rx_q.d == NIB_PREAMBLE;
  endsequence

  jk_start_a: assert property (start_cause_s |-> cg_q == CG_J ##1 cg_q == CG_K)
    else $error("start pair not sent as J then K");

  tr_end_a: assert property (end_cause_s |->
      $past(cg_q) == CG_T && cg_q == CG_R ##1 cg_q == CG_IDLE)
    else $error("end pair not sent as T then R then idle");

  idle_fill_a: assert property (
      tx_st_q == TX_IDLE && !tx_mii_i.en && !tx_bypass_i |=> cg_q == CG_IDLE)
    else $error("idle not sent between packets");

  data_map_a: assert property (
      tx_st_q == TX_DATA && tx_mii_i.en && !tx_mii_i.er && !tx_bypass_i
      |=> cg_q == ENC_TABLE[$past(tx_mii_i.d)])
    else $error("data nibble mapped to wrong group");

  bypass_pass_a: assert property (
      tx_bypass_i |=> cg_q == $past({tx_mii_i.er, tx_mii_i.d}) && tx_st_q == TX_IDLE)
    else $error("bypass did not pass the raw group");

  mlt_excl_a: assert property ((tx_line_o.pos & tx_line_o.neg) == '0)
    else $error("both drive phases active in one slot");

  jk_align_a: assert property (
      rx_st_q == RX_HUNT && locked && hit
      |=> rx_st_q == RX_PRE1 && off_q == $past(hit_off) ##2 rx_st_q == RX_DATA)
    else $error("start pair did not open an aligned frame");

  rx_preamble_a: assert property (rx_st_q == RX_PRE1 |=> preamble_pair_s)
    else $error("start pair not replaced by two preamble nibbles");

  rx_strip_a: assert property (
      rx_st_q == RX_DATA && g2_q == CG_T && g1_q == CG_R |=> !rx_q.dv ##1 !rx_q.dv)
    else $error("end pair reached the MII with valid set");

  rx_invalid_a: assert property (
      rx_st_q == RX_DATA && g2_q != CG_IDLE && !(g2_q == CG_T && g1_q == CG_R)
      && !dec.ok |=> rx_q.dv && rx_q.er)
    else $error("invalid group not flagged as error");

endmodule

// File: sim/fpc_mac_model.sv
module fpc_mac_model
  import fpc_pkg::*;
(
  input wire logic mclk_i,          // MII clock
  input wire logic resetn_i,        // Async reset, active low
  output fpc_mii_tx_s tx_mii_o,     // Transmit group to the device
  output logic tx_bypass_o,         // Raw group select
  input wire fpc_mii_rx_s rx_mii_i  // Receive group from the device
);
  timeunit 1ns;
  timeprecision 1ps;

  logic [4:0] rxq[$];

  // Quiet bus until a frame is asked for
  initial begin
    tx_mii_o = '0;
    tx_bypass_o = 1'b0;
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Keep every nibble marked valid, as {er,d}
  always @(posedge mclk_i) begin
    if (resetn_i === 1'b1 && rx_mii_i.dv === 1'b1) begin
      rxq.push_back({rx_mii_i.er, rx_mii_i.d});
    end
  end

  // One nibble per clock with enable held, or raw groups with enable low in bypass
  task automatic send(input logic [4:0] q[$], input logic byp);
    foreach (q[i]) begin
      @(posedge mclk_i);
      tx_mii_o <= '{en: !byp, er: q[i][4], d: q[i][3:0]};
      tx_bypass_o <= byp;
    end
    @(posedge mclk_i);
    tx_mii_o <= '0;
    tx_bypass_o <= 1'b0;
  endtask
endmodule

// File: sim/fpc_pcs_coding_tb.sv
module fpc_pcs_coding_tb;
  timeunit 1ns;
  timeprecision 1ps;
  import fpc_pkg::*;

  logic mclk_i;
  logic resetn_i;
  logic tx_bypass_i;
  logic rx_lock_o;
  fpc_mii_tx_s tx_mii_i;
  fpc_mii_rx_s rx_mii_o;
  fpc_line_s tx_line_o;
  fpc_line_s rx_line_i;
  int n_fail = 0;
  int n_compared = 0;
  logic [4:0] txg[$];
  logic [10:0] h;
  int lvl;
  int lastnz;
  int nw;

  // Short lock count keeps the run brief
  fpc_pcs_coding #(.LOCK_CNT(1)) u_fpc_pcs_coding (
    .mclk_i(mclk_i),
    .resetn_i(resetn_i),
    .tx_mii_i(tx_mii_i),
    .tx_bypass_i(tx_bypass_i),
    .tx_line_o(tx_line_o),
    .rx_line_i(rx_line_i),
    .rx_mii_o(rx_mii_o),
    .rx_lock_o(rx_lock_o)
  );

  fpc_mac_model u_fpc_mac_model (
    .mclk_i(mclk_i),
    .resetn_i(resetn_i),
    .tx_mii_o(tx_mii_i),
    .tx_bypass_o(tx_bypass_i),
    .rx_mii_i(rx_mii_o)
  );

  // 25 MHz clock
  initial begin
    mclk_i = 1'b0;
    forever #20 mclk_i = ~mclk_i;
  end

  // Loop the drive phases back, one clock late like a short cable
  initial rx_line_i = '0;
  always @(posedge mclk_i) rx_line_i <= tx_line_o;

  ////////////////////////////////////////////////////////////////////////////////
  task automatic check(input logic [19:0] seen, input logic [19:0] exp);
    n_compared++;
    if (seen !== exp) begin
      n_fail++;
      $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic give_verdict();
    $display("compared %0d, mismatches %0d", n_compared, n_fail);
    if (n_fail == 0 && n_compared > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask

  // Rebuild groups from the phases; idle teaches the key, so the
  // key phase after reset need not be known
  always @(posedge mclk_i) begin
    logic [4:0] g;
    int v;
    logic b;
    logic k;
    if (resetn_i !== 1'b1) begin
      nw = 0;
      lvl = 0;
      lastnz = 0;
    end else begin
      for (int i = 4; i >= 0; i--) begin
        v = tx_line_o.pos[i] ? 1 : (tx_line_o.neg[i] ? -1 : 0);
        // A step off zero must take the sign opposite the last nonzero level; a held level repeats its sign
        if (v != 0 && lvl == 0 && lastnz != 0) check(20'(v), 20'(-lastnz));
        if (v != 0) lastnz = v;
        b = (v != lvl);
        lvl = v;
        k = (nw < 6) ? !b : (h[10] ^ h[8]);
        h = {h[9:0], k};
        g[i] = b ^ k;
      end
      nw++;
      if (nw > 6) txg.push_back(g);
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Send, let the pipes drain, then judge both line and receive side
  task automatic run(input logic [4:0] nq[$], input logic [4:0] gq[$],
                     input logic [4:0] rq[$], input logic byp);
    int i;
    txg = {};
    u_fpc_mac_model.rxq = {};
    u_fpc_mac_model.send(nq, byp);
    repeat (12) @(posedge mclk_i);
    i = 0;
    while (i < txg.size() && txg[i] === CG_IDLE) i++;
    foreach (gq[j]) check(txg[i + j], gq[j]);
    check(txg[i + gq.size()], CG_IDLE);
    check(20'(u_fpc_mac_model.rxq.size()), 20'(rq.size()));
    foreach (rq[j]) check(u_fpc_mac_model.rxq[j], rq[j]);
  endtask

  // Look after the first edge, so a missed time-zero reset edge cannot leave X
  task automatic t_reset();
    @(posedge mclk_i);
    #1;
    check({tx_line_o, rx_mii_o, rx_lock_o}, 20'h0);
    @(posedge mclk_i);
    resetn_i <= 1'b1;
    repeat (20) @(posedge mclk_i);
    check(rx_lock_o, 1'b1);
    $display("test reset done");
  endtask

  // Full nibble range after preamble
  task automatic t_data();
    logic [4:0] nq[$];
    logic [4:0] gq[$];
    nq = {5'h05, 5'h05, 5'h05, 5'h05};
    gq = {CG_J, CG_K, ENC_TABLE[5], ENC_TABLE[5]};
    for (int n = 0; n < 16; n++) begin
      nq.push_back(5'(n));
      gq.push_back(ENC_TABLE[n]);
    end
    gq.push_back(CG_T);
    gq.push_back(CG_R);
    run(nq, gq, nq, 1'b0);
    $display("test data done");
  endtask

  // Boundary: only the two replaced preamble nibbles
  task automatic t_short();
    run({5'h05, 5'h05}, {CG_J, CG_K, CG_T, CG_R}, {5'h05, 5'h05}, 1'b0);
    $display("test short done");
  endtask

  // Error during data goes out as the error symbol
  task automatic t_txer();
    run({5'h05, 5'h05, 5'h13, 5'h07}, {CG_J, CG_K, CG_ERR, ENC_TABLE[7], CG_T, CG_R},
        {5'h05, 5'h05, 5'h10, 5'h07}, 1'b0);
    $display("test txer done");
  endtask

  // Raw groups, every invalid code among them
  task automatic t_bypass();
    logic [4:0] inv[$];
    logic [4:0] rq[$];
    inv = {5'h00, 5'h01, 5'h02, 5'h03, 5'h05, 5'h06, 5'h08, 5'h0c, 5'h10, 5'h19};
    rq = {5'h05, 5'h05};
    foreach (inv[j]) rq.push_back(5'h10);
    run({CG_J, CG_K, inv, CG_T, CG_R, CG_IDLE, CG_IDLE}, {CG_J, CG_K, inv, CG_T, CG_R},
        rq, 1'b1);
    $display("test bypass done");
  endtask

  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    resetn_i = 1'b0;
    t_reset();
    t_data();
    t_short();
    t_txer();
    t_bypass();
    give_verdict();
  end

  // Whole run is about 120 clocks; far past that means a hang
  initial begin
    #(40 * 3000);
    n_fail++;
    give_verdict();
  end
endmodule
